// ### pkg/drre_pkg.sv
// Purpose: shared constants and types of the receive result engine.
// Assumes: 20 MHz clock; byte-wide register port at printed offsets.
// Notes:   command codes and field spots of control bytes are local.
`default_nettype none
package drre_pkg;
  // clock and converter timing
  localparam int unsigned CLK_HZ     = 20000000;
  localparam int unsigned SAMPLE_HZ  = 250000;
  localparam int unsigned SAMPLE_DIV = (CLK_HZ + SAMPLE_HZ - 1) / SAMPLE_HZ;
  localparam int          DIV_W      = 7;
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(SAMPLE_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_FIRST = 7'h00;

  // data path widths
  localparam int ADC_W     = 12;
  localparam int VEC_W     = 16;
  localparam int RES_W     = 16;
  localparam int N_SAMPLES = 1024;
  localparam int IDX_W     = 10;
  localparam int ACC_W     = ADC_W + VEC_W + IDX_W;
  localparam int ACC_SHIFT = 12;
  localparam logic [IDX_W-1:0] IDX_FIRST = 10'h000;
  localparam logic [IDX_W-1:0] IDX_LAST  = IDX_W'(N_SAMPLES - 1);
  localparam logic signed [ACC_W-1:0] RES_MAX = ACC_W'(32767);
  localparam logic signed [ACC_W-1:0] RES_MIN = ACC_W'(-32768);
  localparam logic signed [ACC_W-1:0] ACC_ZERO = ACC_W'(0);

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_HI   = 8'h80;
  localparam logic [7:0] ADDR_CTRL_LO   = 8'h81;
  localparam logic [7:0] ADDR_SETTLE_HI = 8'h8a;
  localparam logic [7:0] ADDR_SETTLE_LO = 8'h8b;
  localparam logic [7:0] ADDR_STATUS    = 8'h8f;
  localparam logic [7:0] ADDR_REAL_HI   = 8'h94;
  localparam logic [7:0] ADDR_REAL_LO   = 8'h95;
  localparam logic [7:0] ADDR_IMAG_HI   = 8'h96;
  localparam logic [7:0] ADDR_IMAG_LO   = 8'h97;

  // field positions
  localparam int CMD_LSB                 = 4;
  localparam int CMD_W                   = 4;
  localparam int RECEIVE_GAIN_SELECT_BIT = 0;
  localparam int POINT_DONE_FLAG_BIT     = 2;
  localparam int SETTLE_W                = 9;

  // reset values
  localparam logic [7:0]          CTRL_HI_RST = 8'h00;
  localparam logic [7:0]          CTRL_LO_RST = 8'h00;
  localparam logic [7:0]          SETTLE_RST  = 8'h00;
  localparam logic [7:0]          BYTE_ZERO   = 8'h00;
  localparam logic [SETTLE_W-1:0] CNT_ZERO    = 9'h000;

  // commands in the upper nibble of the high control byte
  localparam logic [CMD_W-1:0] CMD_START   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_REPEAT  = 4'h2;
  localparam logic [CMD_W-1:0] CMD_STANDBY = 4'h3;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_DONE   = 2'b11
  } drre_state_t;

  // one complex point result
  typedef struct packed {
    logic signed [RES_W-1:0] re;
    logic signed [RES_W-1:0] im;
  } drre_result_t;

  // test vector pair from the frequency synthesizer
  typedef struct packed {
    logic signed [VEC_W-1:0] cos_v;
    logic signed [VEC_W-1:0] sin_v;
  } drre_vec_t;
endpackage
`default_nettype wire

// ### logic/drre_mac.sv
// Purpose: one signed multiply-accumulate lane of the transform.
// Assumes: clr with en loads the first product in place of the sum.
// Notes:   neg subtracts the product, used by the imaginary lane.
`default_nettype none
module drre_mac (
  input  wire logic                                clk,       // clock
  input  wire logic                                reset,     // async
  input  wire logic                                en,        // take
  input  wire logic                                clr,       // restart
  input  wire logic                                neg,       // subtract
  input  wire logic signed [drre_pkg::ADC_W-1:0]   sample_in, // word
  input  wire logic signed [drre_pkg::VEC_W-1:0]   vec_in,    // vector
  output logic signed [drre_pkg::ACC_W-1:0]        acc        // sum
);
  localparam int PW = drre_pkg::ADC_W + drre_pkg::VEC_W;

  logic signed [PW-1:0]                prod;
  logic signed [drre_pkg::ACC_W-1:0]   term;
  logic signed [drre_pkg::ACC_W-1:0]   base;
  logic signed [drre_pkg::ACC_W-1:0]   acc_ff;
  logic signed [drre_pkg::ACC_W-1:0]   nxt_acc;

  // product, sign extended, optionally negated
  assign prod    = sample_in * vec_in;
  assign term    = neg ? -drre_pkg::ACC_W'(prod) : drre_pkg::ACC_W'(prod);
  assign base    = clr ? drre_pkg::ACC_ZERO : acc_ff;
  assign nxt_acc = en ? base + term : acc_ff;
  assign acc     = acc_ff;

  // accumulator
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_ff <= drre_pkg::ACC_ZERO;
    end else begin
      acc_ff <= nxt_acc;
    end
  end
endmodule
`default_nettype wire

// ### logic/drre_engine.sv
// Purpose: receive result engine: settling wait, paced sampling,
//          single-bin transform and result byte registers.
// Assumes: converter words and test vectors are synchronous to clk;
//          test_vec holds the vectors for index vec_index.
// Notes:   results land two cycles after the last sample is taken.
// Operation
// - Control gain bit selects a receive gain of five or one.
// - Each 12-bit 250 kSPS converter word feeds the accumulators directly.
// - Per point sum sample times cosine, and minus sample times sine.
// - Accumulate exactly 1024 samples before a point result completes.
// - Result leaves as separate 16-bit real and imaginary values.
// - Both stored components are signed two's complement numbers.
// - Real component reads at byte addresses 0x94 and 0x95.
// - Imaginary component reads at byte addresses 0x96 and 0x97.
// - Status flag rises when the point measurement completes.
// - Sampling starts only after programmed settling output cycles pass.
`default_nettype none
module drre_engine (
  input  wire logic                              clk,         // 20 MHz
  input  wire logic                              reset,       // async
  input  wire logic [7:0]                        reg_addr,    // byte addr
  input  wire logic                              reg_wr,      // write
  input  wire logic [7:0]                        reg_wdata,   // write byte
  input  wire logic                              reg_rd,      // read
  output logic [7:0]                             reg_rdata,   // read byte
  output logic                                   conv_start,  // pulse
  input  wire logic                              adc_valid,   // word ok
  input  wire logic signed [drre_pkg::ADC_W-1:0] adc_data,    // word
  input  wire drre_pkg::drre_vec_t               test_vec,    // cos, sin
  output logic [drre_pkg::IDX_W-1:0]             vec_index,   // index n
  input  wire logic                              synth_cycle, // per cycle
  output logic                                   rx_gain_x5,  // gain five
  output logic                                   point_done   // status
);

  // register port decode
  logic wr_ctrl_hi;
  logic wr_ctrl_lo;
  logic wr_settle_hi;
  logic wr_settle_lo;

  assign wr_ctrl_hi   = reg_wr && (reg_addr == drre_pkg::ADDR_CTRL_HI);
  assign wr_ctrl_lo   = reg_wr && (reg_addr == drre_pkg::ADDR_CTRL_LO);
  assign wr_settle_hi = reg_wr && (reg_addr == drre_pkg::ADDR_SETTLE_HI);
  assign wr_settle_lo = reg_wr && (reg_addr == drre_pkg::ADDR_SETTLE_LO);

  // command decode from the high control byte
  logic [drre_pkg::CMD_W-1:0] wr_cmd;
  logic                       cmd_go;
  logic                       cmd_standby;

  assign wr_cmd      = reg_wdata[drre_pkg::CMD_LSB +: drre_pkg::CMD_W];
  assign cmd_go      = wr_ctrl_hi && ((wr_cmd == drre_pkg::CMD_START) ||
                                      (wr_cmd == drre_pkg::CMD_REPEAT));
  assign cmd_standby = wr_ctrl_hi && (wr_cmd == drre_pkg::CMD_STANDBY);

  // control and settling registers
  logic [7:0]                    ctrl_hi_ff;
  logic [7:0]                    ctrl_lo_ff;
  logic                          settle_msb_ff;
  logic [7:0]                    settle_lo_ff;
  logic [7:0]                    nxt_ctrl_hi;
  logic [7:0]                    nxt_ctrl_lo;
  logic                          nxt_settle_msb;
  logic [7:0]                    nxt_settle_lo;
  logic [drre_pkg::SETTLE_W-1:0] settle_val;

  assign nxt_ctrl_hi    = wr_ctrl_hi ? reg_wdata : ctrl_hi_ff;
  assign nxt_ctrl_lo    = wr_ctrl_lo ? reg_wdata : ctrl_lo_ff;
  assign nxt_settle_msb = wr_settle_hi ? reg_wdata[0] : settle_msb_ff;
  assign nxt_settle_lo  = wr_settle_lo ? reg_wdata : settle_lo_ff;
  assign settle_val     = {settle_msb_ff, settle_lo_ff};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_hi_ff    <= drre_pkg::CTRL_HI_RST;
      ctrl_lo_ff    <= drre_pkg::CTRL_LO_RST;
      settle_msb_ff <= 1'b0;
      settle_lo_ff  <= drre_pkg::SETTLE_RST;
    end else begin
      ctrl_hi_ff    <= nxt_ctrl_hi;
      ctrl_lo_ff    <= nxt_ctrl_lo;
      settle_msb_ff <= nxt_settle_msb;
      settle_lo_ff  <= nxt_settle_lo;
    end
  end

  // gain bit set means unity gain, clear means gain of five
  assign rx_gain_x5 =
    ~ctrl_hi_ff[drre_pkg::RECEIVE_GAIN_SELECT_BIT];

  // measurement sequencer
  drre_pkg::drre_state_t state_ff;
  drre_pkg::drre_state_t nxt_state;
  logic                  in_settle;
  logic                  in_sample;
  logic                  settle_met;
  logic                  take;
  logic                  take_last;

  logic [drre_pkg::SETTLE_W-1:0] settle_cnt_ff;
  logic [drre_pkg::SETTLE_W-1:0] nxt_settle_cnt;
  logic [drre_pkg::IDX_W-1:0]    idx_ff;
  logic [drre_pkg::IDX_W-1:0]    nxt_idx;
  logic [drre_pkg::DIV_W-1:0]    div_ff;
  logic [drre_pkg::DIV_W-1:0]    nxt_div;
  logic                          last_ff;

  assign in_settle  = (state_ff == drre_pkg::ST_SETTLE);
  assign in_sample  = (state_ff == drre_pkg::ST_SAMPLE);
  assign settle_met = (settle_cnt_ff >= settle_val);
  assign take       = in_sample && adc_valid;
  assign take_last  = take && (idx_ff == drre_pkg::IDX_LAST);

  // next state; a command overrides the running sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      drre_pkg::ST_IDLE: begin
        nxt_state = drre_pkg::ST_IDLE;
      end
      drre_pkg::ST_SETTLE: begin
        if (settle_met) begin
          nxt_state = drre_pkg::ST_SAMPLE;
        end
      end
      drre_pkg::ST_SAMPLE: begin
        if (take_last) begin
          nxt_state = drre_pkg::ST_DONE;
        end
      end
      drre_pkg::ST_DONE: begin
        nxt_state = drre_pkg::ST_DONE;
      end
      default: begin
        nxt_state = drre_pkg::ST_IDLE;
      end
    endcase
    if (cmd_standby) begin
      nxt_state = drre_pkg::ST_IDLE;
    end else if (cmd_go) begin
      nxt_state = drre_pkg::ST_SETTLE;
    end
  end

  // settling counter counts synthesizer output cycles
  always_comb begin
    nxt_settle_cnt = settle_cnt_ff;
    if (cmd_go || cmd_standby) begin
      nxt_settle_cnt = drre_pkg::CNT_ZERO;
    end else if (in_settle && synth_cycle && !settle_met) begin
      nxt_settle_cnt = settle_cnt_ff + 1'b1;
    end
  end

  // sample index, wraps to zero after the last sample
  always_comb begin
    nxt_idx = idx_ff;
    if (cmd_go || cmd_standby) begin
      nxt_idx = drre_pkg::IDX_FIRST;
    end else if (take) begin
      nxt_idx = idx_ff + 1'b1;
    end
  end

  // 250 kSPS conversion pacing, runs only while sampling
  assign nxt_div = !in_sample ? drre_pkg::DIV_FIRST :
                   (div_ff == drre_pkg::DIV_LAST) ? drre_pkg::DIV_FIRST :
                   div_ff + 1'b1;
  assign conv_start = in_sample && (div_ff == drre_pkg::DIV_FIRST) &&
                      !cmd_go && !cmd_standby;
  assign vec_index  = idx_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff      <= drre_pkg::ST_IDLE;
      settle_cnt_ff <= drre_pkg::CNT_ZERO;
      idx_ff        <= drre_pkg::IDX_FIRST;
      div_ff        <= drre_pkg::DIV_FIRST;
      last_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      settle_cnt_ff <= nxt_settle_cnt;
      idx_ff        <= nxt_idx;
      div_ff        <= nxt_div;
      last_ff       <= take_last;
    end
  end

  // transform lanes: real adds x*cos, imaginary subtracts x*sin
  logic signed [drre_pkg::ACC_W-1:0] acc_re;
  logic signed [drre_pkg::ACC_W-1:0] acc_im;
  logic                              first_take;

  assign first_take = (idx_ff == drre_pkg::IDX_FIRST);

  drre_mac u_mac_re (
    .clk       (clk),
    .reset     (reset),
    .en        (take),
    .clr       (first_take),
    .neg       (1'b0),
    .sample_in (adc_data),
    .vec_in    (test_vec.cos_v),
    .acc       (acc_re)
  );

  drre_mac u_mac_im (
    .clk       (clk),
    .reset     (reset),
    .en        (take),
    .clr       (first_take),
    .neg       (1'b1),
    .sample_in (adc_data),
    .vec_in    (test_vec.sin_v),
    .acc       (acc_im)
  );

  // scale a full sum to a saturated signed 16-bit result
  function automatic logic signed [drre_pkg::RES_W-1:0] to_res(
    input logic signed [drre_pkg::ACC_W-1:0] a
  );
    logic signed [drre_pkg::ACC_W-1:0] s;
    s = a >>> drre_pkg::ACC_SHIFT;
    if (s > drre_pkg::RES_MAX) begin
      s = drre_pkg::RES_MAX;
    end else if (s < drre_pkg::RES_MIN) begin
      s = drre_pkg::RES_MIN;
    end
    return s[drre_pkg::RES_W-1:0];
  endfunction

  // both components captured in the same cycle
  drre_pkg::drre_result_t res_ff;
  drre_pkg::drre_result_t nxt_res;

  always_comb begin
    nxt_res = res_ff;
    if (last_ff) begin
      nxt_res.re = to_res(acc_re);
      nxt_res.im = to_res(acc_im);
    end
  end

  // completion flag: set wins over a clearing command
  logic point_done_ff;
  logic nxt_point_done;

  assign nxt_point_done = last_ff ||
                          (point_done_ff && !cmd_go && !cmd_standby);
  assign point_done     = point_done_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      res_ff        <= '0;
      point_done_ff <= 1'b0;
    end else begin
      res_ff        <= nxt_res;
      point_done_ff <= nxt_point_done;
    end
  end

  // read data select
  logic [7:0] rd_byte;
  logic [7:0] status_byte;

  assign status_byte =
    8'(point_done_ff) << drre_pkg::POINT_DONE_FLAG_BIT;

  always_comb begin
    if (reg_addr == drre_pkg::ADDR_CTRL_HI) begin
      rd_byte = ctrl_hi_ff;
    end else if (reg_addr == drre_pkg::ADDR_CTRL_LO) begin
      rd_byte = ctrl_lo_ff;
    end else if (reg_addr == drre_pkg::ADDR_SETTLE_HI) begin
      rd_byte = 8'(settle_msb_ff);
    end else if (reg_addr == drre_pkg::ADDR_SETTLE_LO) begin
      rd_byte = settle_lo_ff;
    end else if (reg_addr == drre_pkg::ADDR_STATUS) begin
      rd_byte = status_byte;
    end else if (reg_addr == drre_pkg::ADDR_REAL_HI) begin
      rd_byte = res_ff.re[15:8];
    end else if (reg_addr == drre_pkg::ADDR_REAL_LO) begin
      rd_byte = res_ff.re[7:0];
    end else if (reg_addr == drre_pkg::ADDR_IMAG_HI) begin
      rd_byte = res_ff.im[15:8];
    end else if (reg_addr == drre_pkg::ADDR_IMAG_LO) begin
      rd_byte = res_ff.im[7:0];
    end else begin
      rd_byte = drre_pkg::BYTE_ZERO;
    end
  end

  // read byte held until the next read strobe
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_reg_rdata;

  assign nxt_reg_rdata = reg_rd ? rd_byte : reg_rdata_ff;
  assign reg_rdata     = reg_rdata_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_ff <= drre_pkg::BYTE_ZERO;
    end else begin
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

endmodule
`default_nettype wire

// ### verif/drre_engine_chk.sv
// Purpose: port checks of the receive result engine.
// Assumes: one clock, asynchronous active-high reset.
// Notes:   bound to every engine instance.
`default_nettype none
module drre_engine_chk (
  input wire logic                       clk,         // clock
  input wire logic                       reset,       // async
  input wire logic [7:0]                 reg_addr,    // byte addr
  input wire logic                       reg_wr,      // write
  input wire logic [7:0]                 reg_wdata,   // write byte
  input wire logic                       reg_rd,      // read
  input wire logic [7:0]                 reg_rdata,   // read byte
  input wire logic                       conv_start,  // start pulse
  input wire logic                       adc_valid,   // word ok
  input wire logic [drre_pkg::IDX_W-1:0] vec_index,   // index
  input wire logic                       synth_cycle, // cycle pulse
  input wire logic                       rx_gain_x5,  // gain five
  input wire logic                       point_done   // status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [6:0] gap_ff;
  logic [9:0] syn_ff;
  logic [8:0] set_ff;
  logic [6:0] nxt_gap;
  logic [9:0] nxt_syn;
  wire        ctl_wr = reg_wr && reg_addr == 8'h80;
  wire        cmd_wr = ctl_wr && reg_wdata[7:5] == 3'h0 && reg_wdata[4];
  wire        rpt_wr = ctl_wr && reg_wdata[7:4] == 4'h2;
  // gap since last start, synth cycles since last command
  assign nxt_gap = (cmd_wr || rpt_wr) ? 7'h7f : conv_start ? 7'h00 :
                   gap_ff + {6'h00, gap_ff != 7'h7f};
  assign nxt_syn = (cmd_wr || rpt_wr) ? 10'h000 :
                   syn_ff + {9'h000, synth_cycle && syn_ff != 10'h3ff};
  // trackers, settle count shadowed from its two bytes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_ff <= 7'h7f;
      syn_ff <= 10'h000;
      set_ff <= 9'h000;
    end else begin
      gap_ff <= nxt_gap;
      syn_ff <= nxt_syn;
      if (reg_wr && reg_addr == 8'h8a) set_ff[8] <= reg_wdata[0];
      if (reg_wr && reg_addr == 8'h8b) set_ff[7:0] <= reg_wdata;
    end
  end
  a_gain_select: assert property (
    ctl_wr |=> rx_gain_x5 == !$past(reg_wdata[0]))
    else $error("gain output wrong after control write");
  a_status_read: assert property (
    reg_rd && reg_addr == 8'h8f |=>
      reg_rdata == {5'h00, $past(point_done), 2'h0})
    else $error("status byte wrong");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > 8'h97 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_done_holds: assert property (
    point_done && !ctl_wr |=> point_done)
    else $error("done flag dropped without command");
  a_done_clear: assert property (
    (cmd_wr || rpt_wr) && !$past(adc_valid) |=> !point_done)
    else $error("done flag kept after new command");
  a_conv_spacing: assert property (
    conv_start |-> gap_ff >= 7'h4f)
    else $error("converter starts closer than 80 clocks");
  a_settle_first: assert property (
    conv_start |-> syn_ff >= {1'b0, set_ff})
    else $error("sampling began before settling finished");
  a_index_step: assert property (
    vec_index != $past(vec_index) |-> vec_index == 10'h000 ||
      ($past(adc_valid) && vec_index == $past(vec_index) + 10'h001))
    else $error("sample index moved wrongly");
  a_done_after_last: assert property (
    $rose(point_done) |->
      $past(adc_valid, 2) && $past(vec_index, 2) == 10'h3ff)
    else $error("point completed off the 1024th sample");
  c_point_done: cover property ($rose(point_done));
  c_conv_start: cover property (conv_start);
  c_read_real: cover property (reg_rd && reg_addr == 8'h94);
endmodule
bind drre_engine drre_engine_chk u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_start(conv_start), .adc_valid(adc_valid), .vec_index(vec_index),
  .synth_cycle(synth_cycle), .rx_gain_x5(rx_gain_x5),
  .point_done(point_done));
`default_nettype wire

// ### verif/drre_far_model.sv
// Purpose: converter and synthesizer stand-in facing the engine.
// Assumes: hold high drops any word in flight.
// Notes:   fast paces words itself, slow answers each start.
`default_nettype none
module drre_far_model #(
  parameter int SYNTH_DIV = 50, // clocks per output cycle
  parameter int SLOW_LAT  = 5   // start to word latency
) (
  input  wire logic               clk,         // clock
  input  wire logic               reset,       // async
  input  wire logic               hold,        // drop work
  input  wire logic               fast,        // free pace
  input  wire logic               conv_start,  // start pulse
  input  wire logic [9:0]         vec_index,   // index
  input  wire logic [11:0]        sample_in,   // next word
  output logic                    adc_valid,   // word ok
  output logic signed [11:0]      adc_data,    // word
  output var drre_pkg::drre_vec_t test_vec,    // vectors
  output logic                    synth_cycle  // cycle pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic                armed_ff;
  logic [SLOW_LAT-1:0] pipe_ff;
  logic [1:0]          tick_ff;
  logic [7:0]          syn_ff;
  logic                nxt_valid;
  // small signed vectors keep sums clear of saturation
  function automatic drre_pkg::drre_vec_t vec_of(input logic [9:0] k);
    vec_of = {{10{k[5]}}, k[5:0], {11{k[8]}}, k[8:4]};
  endfunction
  // vectors follow the index, word pacing per mode
  assign test_vec  = vec_of(vec_index);
  assign nxt_valid = !hold && (fast ? armed_ff && tick_ff == 2'h3
                                    : pipe_ff[SLOW_LAT-1]);
  // word and synthesizer cycle timing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_ff    <= 1'b0;
      pipe_ff     <= '0;
      tick_ff     <= 2'h0;
      syn_ff      <= 8'h00;
      synth_cycle <= 1'b0;
      adc_valid   <= 1'b0;
      adc_data    <= 12'h000;
    end else begin
      armed_ff    <= !hold && (armed_ff || conv_start);
      pipe_ff     <= hold ? '0 : {pipe_ff[SLOW_LAT-2:0], conv_start};
      tick_ff     <= tick_ff + 2'h1;
      syn_ff      <= (syn_ff == 8'(SYNTH_DIV - 1)) ? 8'h00 : syn_ff + 8'h01;
      synth_cycle <= syn_ff == 8'(SYNTH_DIV - 1);
      adc_valid   <= nxt_valid;
      adc_data    <= nxt_valid ? sample_in : ~adc_data;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_dft_receive_result_engine.sv
// Purpose: self-checking bench of the receive result engine.
// Assumes: settle of two synth cycles, words from the far model.
// Notes:   random words from an lfsr seeded at 46.
`default_nettype none
module tb_dft_receive_result_engine;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, reg_wr, reg_rd, hold, fast, cst;
  logic conv_start, adc_valid, synth_cycle, rx_gain_x5, point_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] sample_in;
  logic [15:0] lfsr = 16'h002e;
  logic signed [11:0] adc_data;
  logic [9:0] vec_index;
  logic [31:0] ri, old, got;
  real gf, m, m_cal;
  localparam real ZCAL = 200000.0; // calibration impedance, ohms
  drre_pkg::drre_vec_t test_vec, v;
  int k, n_fail, total_checks, cyc;
  longint acc_re, acc_im;
  drre_engine dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .adc_valid(adc_valid), .adc_data(adc_data),
    .test_vec(test_vec), .vec_index(vec_index),
    .synth_cycle(synth_cycle), .rx_gain_x5(rx_gain_x5),
    .point_done(point_done));
  drre_far_model u_far (
    .clk(clk), .reset(reset), .hold(hold), .fast(fast),
    .conv_start(conv_start), .vec_index(vec_index),
    .sample_in(sample_in), .adc_valid(adc_valid), .adc_data(adc_data),
    .test_vec(test_vec), .synth_cycle(synth_cycle));
  function automatic drre_pkg::drre_vec_t vec_exp(input logic [9:0] i);
    vec_exp = {{10{i[5]}}, i[5:0], {11{i[8]}}, i[8:4]};
  endfunction
  function automatic logic [15:0] sat(input longint a);
    longint s;
    s = a >>> 12;
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    sat = s[15:0];
  endfunction
  // host view: squared magnitude of a read result pair
  function automatic longint mag2(input logic [31:0] r);
    longint a, b;
    a = longint'($signed(r[31:16]));
    b = longint'($signed(r[15:0]));
    mag2 = a * a + b * b;
  endfunction
  // next random word, 16-bit maximal length register
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    got = {got[23:0], reg_rdata};
    check(reg_rdata, e);
  endtask
  task command(input logic [7:0] c);
    hold = 1'b1;
    wr(8'h80, c);
    hold = 1'b0;
  endtask
  task wait_k(input int n);
    for (int t = 0; t < 3000 && k < n; t++) @(negedge clk);
  endtask
  task finish_point;
    for (int t = 0; t < 6000 && point_done !== 1'b1; t++) @(negedge clk);
    check(k, 1024);
    ri = {sat(acc_re), sat(acc_im)};
    repeat (40) @(negedge clk);
    for (int i = 0; i < 4; i++)
      rd(8'h94 + 8'(i),
         ri[31 - 8 * i -: 8]);
    // host side: magnitude, then impedance against the first point
    check(32'(mag2(got)), 32'(mag2(ri)));
    m = $sqrt(real'(mag2(got)));
    if (gf == 0.0) begin
      gf = 1.0 / (ZCAL * m);
      m_cal = $sqrt(real'(mag2(ri)));
    end
    check(32'(longint'(1.0 / (gf * m))),
          32'(longint'(ZCAL * m_cal / $sqrt(real'(mag2(ri))))));
    rd(8'h8f, 8'h04);
  endtask
  task print_verdict;
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // words for the far model, random or fixed negative
  always @(negedge clk) begin
    lfsr <= lfsr_next(lfsr);
    sample_in <= cst ? 12'h800 : lfsr[11:0];
  end
  // expected sums over the words the engine should take
  always @(posedge clk) begin
    #10;
    if (hold) begin
      k = 0;
      acc_re = 0;
      acc_im = 0;
    end else if (adc_valid === 1'b1 && k < 1024) begin
      v = vec_exp(10'(k));
      check(vec_index, 32'(k));
      acc_re += longint'(adc_data) * longint'(v.cos_v);
      acc_im -= longint'(adc_data) * longint'(v.sin_v);
      k++;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      check(32'(cyc), 32'h0); // hang limit reached
      print_verdict;
    end
  end
  initial begin
    {reg_wr, reg_rd, hold, fast, cst} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check({reg_rdata, point_done, rx_gain_x5, vec_index}, 32'h00000400);
    rd(8'ha5, 8'h00);
    for (int g = 1; g >= 0; g--) begin
      wr(8'h80, 8'(g));
      check(rx_gain_x5, 32'(1 - g));
    end
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h02);
    rd(8'h8b, 8'h02);
    wr(8'h81, 8'h5a);
    rd(8'h81, 8'h5a);
    // paced start, restarted mid-run by repeat at free pace
    command(8'h10);
    wait_k(3);
    fast = 1'b1;
    command(8'h20);
    finish_point;
    // fixed negative words; old results stand meanwhile
    old = ri;
    cst = 1'b1;
    command(8'h10);
    wait_k(8);
    rd(8'h8f, 8'h00);
    rd(8'h94, old[31:24]);
    rd(8'h97, old[7:0]);
    finish_point;
    command(8'h30);
    rd(8'h8f, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
